// File: logic/mrhs_seq.sv
/*
 * Module reset and hibernate wake sequencer, device side.
 * Assumes the host drives the reset and hibernate pins synchronous to CORE_CLK_I.
 */
`timescale 1ns/10ps
module mrhs_seq
   import mrhs_pkg::*;
#(
   parameter int unsigned ROM_INIT_MS_P = ROM_INIT_MS,
   parameter int unsigned CYC_PER_MS_P  = CYC_PER_MS,
   parameter int unsigned CYC_10US_P    = CYC_PER_10US,
   parameter int unsigned CAL_AGE_MS_P  = CAL_AGE_S * MS_PER_S
) (
   // Clock and reset
   input  wire logic                CORE_CLK_I,
   input  wire logic                RESET_I,
   // Host pins
   input  wire logic                MODULE_RESET_LOW_PIN_I,
   input  wire logic                HIBERNATE_CONTROL_LOW_PIN_I,
   // Supply events
   input  wire logic                BROWNOUT_I,
   input  wire logic                BLACKOUT_I,
   // Boot conditions
   input  wire logic [IMG_KB_W-1:0] IMAGE_KB_I,
   input  wire logic                PATCH_PENDING_I,
   input  wire logic [TEMP_W-1:0]   TEMP_DEG_C_I,
   input  wire logic                XTAL_KEEP_DISABLE_I,
   // Status
   output logic                     READY_O,
   output logic                     HIBERNATE_O,
   output logic                     XTAL_EN_O,
   output logic                     CAL_ACTIVE_O,
   output logic                     RUNNING_O
);
   // ************************************************************
   // Declarations
   // ************************************************************
   mrhs_state_e         state_r;
   logic [MS_CNT_W-1:0] ms_r;
   logic [MS_CNT_W-1:0] limit_r;
   logic [IMG_KB_W+3:0] load_r;
   logic [TEMP_W-1:0]   cal_temp_r;
   logic [31:0]         cal_age_ms_r;
   logic                ms_tick;
   logic                us10_tick;
   logic                run;
   logic                reset_held;
   logic                hib_req;
   logic                cal_due;

   initial begin
      if (ROM_INIT_MS_P >= (1 << MS_CNT_W)) $error("mrhs_seq: ROM_INIT_MS_P too large");
      if (CYC_PER_MS_P < 2 || CYC_10US_P < 2) $error("mrhs_seq: clock counts too small");
      if (ROM_INIT_MS_P < 1) $error("mrhs_seq: ROM_INIT_MS_P must be at least 1");
      if (CAL_AGE_MS_P < 1) $error("mrhs_seq: CAL_AGE_MS_P must be at least 1");
      if (HIB_CAL_MS >= (1 << MS_CNT_W)) $error("mrhs_seq: wake count too wide");
   end

   // ************************************************************
   // Functions
   // ************************************************************
   function automatic logic [TEMP_W-1:0] absdiff(input logic [TEMP_W-1:0] a,
                                                input logic [TEMP_W-1:0] b);
      absdiff = (a > b) ? a - b : b - a;
   endfunction

   // Image load length in 10 us steps
   function automatic logic [IMG_KB_W+3:0] load_steps(input logic [IMG_KB_W-1:0] kb);
      load_steps = kb * (IMG_KB_W+4)'(LOAD_NUM_10US);
   endfunction

   assign reset_held = !MODULE_RESET_LOW_PIN_I;
   assign hib_req    = !HIBERNATE_CONTROL_LOW_PIN_I;
   assign run        = (state_r == MRHS_HW_WAKE) || (state_r == MRHS_ROM_INIT)
                    || (state_r == MRHS_HIB_WAKE);
   assign cal_due    = (absdiff(TEMP_DEG_C_I, cal_temp_r) > TEMP_W'(CAL_TEMP_DEG_C))
                    || (cal_age_ms_r >= 32'(CAL_AGE_MS_P));

   // ************************************************************
   // Dividers
   // ************************************************************
   mrhs_tick #(.DIV(CYC_PER_MS_P)) u_ms (
      .clk_i  (CORE_CLK_I),
      .rst_i  (RESET_I),
      .run_i  (run),
      .tick_o (ms_tick)
   );

   mrhs_tick #(.DIV(CYC_10US_P)) u_us10 (
      .clk_i  (CORE_CLK_I),
      .rst_i  (RESET_I),
      .run_i  (state_r == MRHS_IMG_LOAD),
      .tick_o (us10_tick)
   );

   // ************************************************************
   // Sequencer
   // ************************************************************
   always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         state_r <= MRHS_OFF;
         ms_r    <= '0;
         limit_r <= '0;
         load_r  <= '0;
      end else if (reset_held || BLACKOUT_I) begin
         state_r <= MRHS_OFF;
         ms_r    <= '0;
      end else begin
         case (state_r)
            MRHS_OFF: begin
               state_r <= MRHS_HW_WAKE;
               ms_r    <= '0;
            end
            MRHS_HW_WAKE: begin
               state_r <= MRHS_ROM_INIT;
               ms_r    <= '0;
            end
            MRHS_ROM_INIT: begin
               if (ms_tick) begin
                  if (ms_r == MS_CNT_W'(ROM_INIT_MS_P - 1)) begin
                     state_r <= MRHS_IMG_LOAD;
                     ms_r    <= '0;
                     load_r  <= load_steps(IMAGE_KB_I);
                  end else begin
                     ms_r <= ms_r + 1'b1;
                  end
               end
            end
            MRHS_IMG_LOAD: begin
               if (load_r == '0) begin
                  state_r <= MRHS_READY;
               end else if (us10_tick) begin
                  load_r <= load_r - 1'b1;
               end
            end
            MRHS_READY: begin
               if (hib_req) begin
                  state_r <= MRHS_HIBERNATE;
               end else if (BROWNOUT_I) begin
                  state_r <= MRHS_OFF;
               end
            end
            MRHS_HIBERNATE: begin
               if (!hib_req) begin
                  state_r <= MRHS_HIB_WAKE;
                  ms_r    <= '0;
                  if (cal_due) begin
                     limit_r <= MS_CNT_W'(HIB_CAL_MS - 1);
                  end else if (PATCH_PENDING_I) begin
                     limit_r <= MS_CNT_W'(HIB_PATCH_MS - 1);
                  end else begin
                     limit_r <= MS_CNT_W'(HIB_WAKE_MS - 1);
                  end
               end
            end
            MRHS_HIB_WAKE: begin
               if (ms_tick) begin
                  if (ms_r == limit_r) begin
                     state_r <= MRHS_IMG_LOAD;
                     ms_r    <= '0;
                     load_r  <= load_steps(IMAGE_KB_I);
                  end else begin
                     ms_r <= ms_r + 1'b1;
                  end
               end
            end
            default: state_r <= MRHS_OFF;
         endcase
      end
   end

   // ************************************************************
   // Calibration record
   // ************************************************************
   always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         cal_temp_r   <= '0;
         cal_age_ms_r <= '0;
      end else if (state_r == MRHS_HIBERNATE && !hib_req && cal_due) begin
         cal_temp_r   <= TEMP_DEG_C_I;
         cal_age_ms_r <= '0;
      end else if (state_r == MRHS_OFF) begin
         cal_temp_r   <= TEMP_DEG_C_I;
         cal_age_ms_r <= '0;
      end else if (ms_tick && cal_age_ms_r != '1) begin
         cal_age_ms_r <= cal_age_ms_r + 1'b1;
      end
   end

   // ************************************************************
   // Status outputs
   // ************************************************************
   always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         READY_O      <= 1'b0;
         HIBERNATE_O  <= 1'b0;
         XTAL_EN_O    <= 1'b0;
         CAL_ACTIVE_O <= 1'b0;
         RUNNING_O    <= 1'b0;
      end else begin
         READY_O      <= (state_r == MRHS_READY);
         HIBERNATE_O  <= (state_r == MRHS_HIBERNATE);
         XTAL_EN_O    <= (state_r != MRHS_OFF)
                      && !(state_r == MRHS_HIBERNATE && XTAL_KEEP_DISABLE_I);
         CAL_ACTIVE_O <= (state_r == MRHS_HIB_WAKE)
                      && (limit_r == MS_CNT_W'(HIB_CAL_MS - 1));
         RUNNING_O    <= run || (state_r == MRHS_IMG_LOAD);
      end
   end
endmodule // mrhs_seq

// File: logic/mrhs_pkg.sv
/*
 * Package of constants for the module reset and hibernate sequencer.
 * Assumes a single 10 MHz core clock; intervals are counted in ms ticks, except the image load, counted in 10 us ticks.
 */
package mrhs_pkg;
   // ************************************************************
   // Clock and timing
   // ************************************************************
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned MS_PER_S        = 1000;
   localparam int unsigned CYC_PER_MS      = CLK_HZ / MS_PER_S;
   localparam int unsigned RESET_MIN_MS    = 5;
   localparam int unsigned ROM_INIT_MS     = 1100;
   // Load time is image_kb * 6 / 100 ms, done in 10 us steps
   localparam int unsigned LOAD_NUM_10US   = 6;
   localparam int unsigned CYC_PER_10US    = CLK_HZ / 100_000;
   localparam int unsigned HIB_WAKE_MS     = 50;
   localparam int unsigned HIB_PATCH_MS    = 75;
   localparam int unsigned HIB_CAL_MS      = 200;
   localparam int unsigned CAL_TEMP_DEG_C  = 20;
   localparam int unsigned CAL_AGE_HOURS   = 24;
   localparam int unsigned SEC_PER_HOUR    = 3600;
   localparam int unsigned CAL_AGE_S       = CAL_AGE_HOURS * SEC_PER_HOUR;
   localparam int unsigned XTAL_HZ_X1000   = 32_768_000;
   localparam int unsigned IMG_KB_W        = 12;
   localparam int unsigned TEMP_W          = 8;
   localparam int unsigned MS_CNT_W        = 12;

   // ************************************************************
   // Sequencer states
   // ************************************************************
   typedef enum logic [2:0] {
      MRHS_OFF,
      MRHS_HW_WAKE,
      MRHS_ROM_INIT,
      MRHS_IMG_LOAD,
      MRHS_READY,
      MRHS_HIBERNATE,
      MRHS_HIB_WAKE
   } mrhs_state_e;
endpackage

// File: logic/mrhs_tick.sv
/*
 * Tick divider: one-cycle enable pulse every DIV clocks.
 * Assumes the core clock and an asynchronous active-high reset.
 */
`timescale 1ns/10ps
module mrhs_tick #(
   parameter int unsigned DIV = 10000
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Enable pulse
   input  wire logic run_i,
   output logic      tick_o
);
   localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
   logic [W-1:0] cnt_r;

   initial begin
      if (DIV < 2) $error("mrhs_tick: DIV must be at least 2");
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r  <= '0;
         tick_o <= 1'b0;
      end else if (!run_i) begin
         cnt_r  <= '0;
         tick_o <= 1'b0;
      end else if (cnt_r == W'(DIV - 1)) begin
         cnt_r  <= '0;
         tick_o <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 1'b1;
         tick_o <= 1'b0;
      end
   end
endmodule // mrhs_tick

// File: tb/mrhs_properties.sv
/* Pin-level relation checks of the sequencer.
   Assumes the top's ports only; bound after the module. */
`timescale 1ns/10ps
module mrhs_properties (
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RESET_I,
   // Pins and supply
   input wire logic MODULE_RESET_LOW_PIN_I,
   input wire logic HIBERNATE_CONTROL_LOW_PIN_I,
   input wire logic BROWNOUT_I,
   input wire logic BLACKOUT_I,
   input wire logic XTAL_KEEP_DISABLE_I,
   // Status
   input wire logic READY_O,
   input wire logic HIBERNATE_O,
   input wire logic XTAL_EN_O,
   input wire logic CAL_ACTIVE_O,
   input wire logic RUNNING_O
);
   // ********
   // Relations
   // ********
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RESET_I);
   sequence s_hib_low(b);
      !HIBERNATE_CONTROL_LOW_PIN_I && MODULE_RESET_LOW_PIN_I && !BLACKOUT_I && BROWNOUT_I == b;
   endsequence
   a_pin_off: assert property (!MODULE_RESET_LOW_PIN_I |-> ##2 !READY_O && !RUNNING_O)
      else $error("reset pin low left sequence on");
   a_blackout_off: assert property (BLACKOUT_I |-> ##2 !READY_O && !HIBERNATE_O)
      else $error("blackout did not force off");
   a_hib_entry: assert property (s_hib_low(1'b0) ##1 READY_O |=> HIBERNATE_O)
      else $error("hibernate request refused");
   a_brown_ignored: assert property (s_hib_low(1'b1) ##1 HIBERNATE_O |=> HIBERNATE_O)
      else $error("brownout acted in hibernate");
   a_brown_ready: assert property (BROWNOUT_I ##1 READY_O |=> !READY_O)
      else $error("brownout ignored in ready");
   a_xtal_kept: assert property ((!XTAL_KEEP_DISABLE_I)[*2] ##0 HIBERNATE_O |-> XTAL_EN_O)
      else $error("crystal stopped in hibernate");
   a_xtal_off: assert property (XTAL_KEEP_DISABLE_I[*2] ##0 HIBERNATE_O |-> !XTAL_EN_O)
      else $error("crystal ran in hibernate while disabled");
   a_cal_in_wake: assert property (CAL_ACTIVE_O |-> RUNNING_O && !READY_O)
      else $error("calibration outside wake");
   a_hib_quiet: assert property (HIBERNATE_O |-> !READY_O && !RUNNING_O)
      else $error("activity during hibernate");
   a_ready_after: assert property ($rose(READY_O) |-> $past(RUNNING_O))
      else $error("ready without load");
endmodule // mrhs_properties
bind mrhs_seq mrhs_properties u_props (.CORE_CLK_I, .RESET_I, .MODULE_RESET_LOW_PIN_I,
   .HIBERNATE_CONTROL_LOW_PIN_I, .BROWNOUT_I, .BLACKOUT_I, .XTAL_KEEP_DISABLE_I,
   .READY_O, .HIBERNATE_O, .XTAL_EN_O, .CAL_ACTIVE_O, .RUNNING_O);

// File: tb/mrhs_host.sv
/* Host model driving the reset and hibernate pins.
   Assumes callers act just after a rising clock edge. */
`timescale 1ns/10ps
module mrhs_host #(
   parameter int unsigned CPM = 20
) (
   // Clock
   input  wire logic clk_i,
   // Pins
   output logic      rst_pin_o,
   output logic      hib_pin_o
);
   initial begin
      rst_pin_o = 1'b0;
      hib_pin_o = 1'b1;
   end
   task automatic hold(input int unsigned ms);
      repeat (ms * CPM) @(posedge clk_i);
      #1;
   endtask
   task automatic reset_pulse(input int unsigned ms);
      rst_pin_o = 1'b0;
      hold(ms);
      rst_pin_o = 1'b1;
   endtask
   // Hibernate for given ms
   task automatic hibernate(input int unsigned ms);
      hib_pin_o = 1'b0;
      hold(ms);
      hib_pin_o = 1'b1;
   endtask
endmodule // mrhs_host

// File: tb/tb_top.sv
/* Self-checking bench of the sequencer with the host model.
   Assumes the package and design under logic/. */
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
   n_compared++; \
   if ((got) !== (ex)) begin \
      fails++; \
      $display("Error %s expected %0d seen %0d", nm, ex, got); \
   end
module tb_top;
   import mrhs_pkg::*;
   localparam int unsigned CPM = 20;
   localparam int unsigned ROM = 3;
   localparam int unsigned C10 = 2;
   localparam int unsigned AGE = 240;
   typedef struct {int cyc; int ex; logic cal; logic hb; logic xo;} mrhs_note_s;
   logic                clk, rst, brown, black, patch, rdy_q, saw_cal, saw_hib, saw_xoff, xdis;
   logic [IMG_KB_W-1:0] kb;
   logic [TEMP_W-1:0]   temp;
   logic                ready, hib, xtal, cal, run;
   wire                 rst_pin, hib_pin;
   int                  fails = 0, n_compared = 0, cyc = 0, seed = 74, d, g;
   mrhs_note_s          q[$], n;
   int                  ms_t[5] = '{75, 200, 50, 200, 200};
   logic [7:0]          tmp_t[5] = '{8'h2d, 8'h2e, 8'h2e, 8'h2e, 8'h19};
   logic [4:0]          pat_t = 5'h03, cal_t = 5'h1a, xd_t = 5'h04;
   mrhs_seq #(.ROM_INIT_MS_P(ROM), .CYC_PER_MS_P(CPM), .CYC_10US_P(C10),
      .CAL_AGE_MS_P(AGE)) uut (
      .CORE_CLK_I(clk), .RESET_I(rst), .MODULE_RESET_LOW_PIN_I(rst_pin),
      .HIBERNATE_CONTROL_LOW_PIN_I(hib_pin), .BROWNOUT_I(brown), .BLACKOUT_I(black),
      .IMAGE_KB_I(kb), .PATCH_PENDING_I(patch), .TEMP_DEG_C_I(temp),
      .XTAL_KEEP_DISABLE_I(xdis), .READY_O(ready), .HIBERNATE_O(hib), .XTAL_EN_O(xtal),
      .CAL_ACTIVE_O(cal), .RUNNING_O(run));
   mrhs_host #(.CPM(CPM)) host (.clk_i(clk), .rst_pin_o(rst_pin), .hib_pin_o(hib_pin));
   // ********
   // Checking
   // ********
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cal === 1'b1)
         saw_cal = 1'b1;
      if (hib === 1'b1)
         saw_hib = 1'b1;
      if (hib === 1'b1 && xtal === 1'b0)
         saw_xoff = 1'b1;
      if (ready === 1'b1 && rdy_q !== 1'b1) begin
         `CHK("notes_pending", 1, q.size())
         if (q.size() > 0)
            n = q.pop_front();
         d = cyc - n.cyc;
         g = (d + 2 >= n.ex && d <= n.ex + 8) ? n.ex : d;
         `CHK("wake_cycles", n.ex, g)
         `CHK("cal_seen", n.cal, saw_cal)
         `CHK("hib_seen", n.hb, saw_hib)
         `CHK("xtal_off_seen", n.xo, saw_xoff)
         saw_cal = 1'b0;
         saw_hib = 1'b0;
         saw_xoff = 1'b0;
      end
      rdy_q = ready;
   end
   // ********
   // Stimulus
   // ********
   task automatic note(input int unsigned ms, input logic c, input logic h, input logic x);
      kb = IMG_KB_W'($unsigned($random(seed)) % 16);
      q.push_back('{cyc, ms * CPM + kb * LOAD_NUM_10US * C10, c, h, x});
   endtask
   task automatic wait_done;
      while (q.size() > 0)
         @(posedge clk);
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic pulse_supply(input logic b);
      if (b) black = 1'b1;
      else brown = 1'b1;
      @(posedge clk);
      #1 brown = 1'b0;
      black = 1'b0;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      end_of_test();
   end
   initial begin
      {rst, brown, black, patch, rdy_q, saw_cal, saw_hib, saw_xoff, xdis} = 9'h100;
      temp = 8'h19;
      kb = '0;
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      host.reset_pulse(RESET_MIN_MS);
      note(ROM, 1'b0, 1'b0, 1'b0);
      wait_done();
      pulse_supply(1'b0);
      host.reset_pulse(200);
      note(ROM, 1'b0, 1'b0, 1'b0);
      wait_done();
      for (int i = 0; i < 5; i++) begin
         temp = tmp_t[i];
         patch = pat_t[i];
         xdis = xd_t[i];
         fork
            host.hibernate(10);
            begin
               repeat (40) @(posedge clk);
               #1 pulse_supply(1'b0);
            end
         join
         note(ms_t[i], cal_t[i], 1'b1, xd_t[i]);
         wait_done();
      end
      pulse_supply(1'b1);
      note(ROM, 1'b0, 1'b0, 1'b0);
      wait_done();
      host.hold(200);
      end_of_test();
   end
endmodule // tb_top
